/* File: rtl/smsc_core.sv */
/*
  serial peripheral core: controller or target, eight-bit full-duplex
  exchange, registers over AXI4-Lite.
  assumes one clock, pins split into in/out/enable, and a bus master
  that keeps one write and one read outstanding at most.
*/
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
module smsc_core
	import smsc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [SMSC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [SMSC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	input wire logic ss_n_in,
	output logic ss_n_out,
	output logic ss_n_oe,
	output logic irq_request,
	output logic wake_request
);
	smsc_ctrl_type ctrl; // control register
	logic double_rate; // status bit 0, software owned
	logic transfer_done_flag; // sticky end of byte
	logic write_collision_flag; // sticky write while busy
	logic armed; // status read seen with a flag up
	logic [7:0] sh; // exchange shift register
	logic [7:0] tx_byte; // last byte loaded, for target restore
	logic [7:0] rx_buf; // receive buffer
	logic [7:0] rx_sh; // incoming bits, kept apart from the outgoing shifter
	logic [1:0] samp_dly; // controller sample strobes waiting out the pin synchroniser
	logic [1:0] done_dly; // controller end of byte, delayed alike
	logic out_bit; // bit presented on the outgoing data pin
	logic sck_phase; // controller clock away from idle
	logic sck_prev; // previous synchronised clock
	logic [2:0] bit_cnt; // sampled bits of the current byte
	logic [4:0] edge_cnt; // controller clock edges so far
	logic [6:0] div_cnt; // controller half period counter
	smsc_state_type state;
	smsc_state_type next_state;
	logic [3:0] pins_s; // synchronised sck, mosi, miso, ss_n

	// all pins cross into ref_clk here; select idles high
	smsc_sync #(.WIDTH(4), .RESET_VALUE(4'h1)) u_sync
	(
		.ref_clk(ref_clk),
		.reset(reset),
		.async_in({sck_in, mosi_in, miso_in, ss_n_in}),
		.sync_out(pins_s)
	);

	wire sck_s = pins_s[3];
	wire mosi_s = pins_s[2];
	wire miso_s = pins_s[1];
	wire ss_n_s = pins_s[0];

	// bus decode: write address and data are taken together
	wire write_fire = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	wire read_fire = s_axi_arvalid & ~s_axi_rvalid;
	wire wr_ctrl = write_fire & (s_axi_awaddr == SMSC_OFS_CTRL);
	wire wr_stat = write_fire & (s_axi_awaddr == SMSC_OFS_STATUS);
	wire wr_data = write_fire & (s_axi_awaddr == SMSC_OFS_DATA);
	wire wr_mapped = wr_ctrl | wr_stat | wr_data;
	wire rd_ctrl = s_axi_araddr == SMSC_OFS_CTRL;
	wire rd_stat = s_axi_araddr == SMSC_OFS_STATUS;
	wire rd_data = s_axi_araddr == SMSC_OFS_DATA;
	wire rd_mapped = rd_ctrl | rd_stat | rd_data;
	wire data_write = wr_data & s_axi_wstrb[0];
	// a data register read, or a data write with byte lane 0 enabled, completes the flag clear sequence
	wire data_access = data_write | (read_fire & rd_data);

	assign s_axi_awready = write_fire;
	assign s_axi_wready = write_fire;
	assign s_axi_arready = read_fire;

	// roles and pin directions
	wire is_ctrl = ctrl.enable & ctrl.controller_select;
	wire is_tgt = ctrl.enable & ~ctrl.controller_select;
	wire tgt_active = is_tgt & ~ss_n_s; // [RL8]
	wire mode_fault = is_ctrl & ~ctrl.ss_is_output & ~ss_n_s; // [RL22]

	assign sck_oe = is_ctrl; // [RL16]
	assign mosi_oe = is_ctrl; // [RL16]
	assign ss_n_oe = is_ctrl & ctrl.ss_is_output; // [RL16]
	assign miso_oe = tgt_active & ctrl.miso_user_en; // [RL8] [RL16]
	assign ss_n_out = ctrl.ss_level; // [RL4] [RL5]
	assign mosi_out = out_bit; // [RL6]
	assign miso_out = out_bit; // [RL6]
	assign sck_out = ctrl.cpol ^ sck_phase; // [RL23]
	assign irq_request = transfer_done_flag & ctrl.irq_enable; // [RL3]

	// controller timing: half period from the rate table
	wire [1:0] rate = {ctrl.rate_select_hi, ctrl.rate_select_lo};
	wire [6:0] half = double_rate ? SMSC_HALF_DOUBLE[rate] : SMSC_HALF_NORMAL[rate]; // [RL18] [RL24]
	// >= keeps the engine alive if the rate drops mid byte
	wire tick = (state == SMSC_SHIFT) & is_ctrl & (div_cnt >= half);
	wire last_edge = edge_cnt == SMSC_LAST_EDGE;
	wire sample_c = tick & (edge_cnt[0] == ctrl.cpha); // [RL23]
	wire setup_c = tick & (edge_cnt[0] != ctrl.cpha);
	wire done_c = tick & last_edge; // [RL2]

	// target timing: edges of the synchronised clock
	wire edge_t = tgt_active & (sck_s ^ sck_prev); // [RL8]
	wire leading_t = sck_s != ctrl.cpol; // [RL23]
	wire sample_t = edge_t & (leading_t ^ ctrl.cpha); // [RL23]
	wire setup_t = edge_t & ~(leading_t ^ ctrl.cpha);
	wire done_t = sample_t & (bit_cnt == SMSC_LAST_BIT); // [RL10]

	// shared datapath
	wire sample = sample_c | sample_t;
	wire setup = setup_c | setup_t;
	wire in_bit = is_ctrl ? miso_s : mosi_s; // [RL6]
	wire [7:0] shifted = ctrl.bit_order_select ? {in_bit, sh[7:1]} : {sh[6:0], in_bit}; // [RL17]
	wire sh_first = ctrl.bit_order_select ? sh[0] : sh[7]; // [RL17]
	wire wd_first = ctrl.bit_order_select ? s_axi_wdata[0] : s_axi_wdata[7];
	wire [7:0] sh_keep = sample ? shifted : sh; // shifter value when nothing is loaded
	// the synchronised data pin lags the clock we drive by two cycles, so the
	// controller takes each bit two cycles after its sampling edge; this costs
	// two cycles of flag latency but keeps the fastest rates usable
	wire rx_take = sample_t | samp_dly[1]; // [RL6]
	wire [7:0] rx_shifted = ctrl.bit_order_select ? {in_bit, rx_sh[7:1]} : {rx_sh[6:0], in_bit}; // [RL17]
	wire [7:0] rx_next = rx_take ? rx_shifted : rx_sh;
	wire xfer_done = done_dly[1] | done_t; // [RL2] [RL10]

	// a target byte is under way once its first bit is in
	wire busy = (state == SMSC_SHIFT) | (tgt_active & (bit_cnt != 3'h0));
	wire collide = data_write & busy; // [RL19]
	wire load = data_write & ~busy; // [RL9] [RL11] [RL25]
	wire start = load & is_ctrl & ~mode_fault; // [RL1] [RL7]
	wire tgt_drop = is_tgt & ss_n_s & (bit_cnt != 3'h0); // [RL21]
	wire bit_clr = start | ~ctrl.enable | (is_tgt & ss_n_s); // [RL21]

	// readback words
	wire [31:0] status_word = (32'(transfer_done_flag) << SMSC_STAT_FLAG_BIT)
		| (32'(write_collision_flag) << SMSC_STAT_WRITE_COLLISION_FLAG_BIT)
		| (32'(double_rate) << SMSC_STAT_DOUBLE_BIT);
	wire [31:0] read_word = rd_ctrl ? {21'h0, ctrl}
		: rd_stat ? status_word
		: rd_data ? {24'h000000, rx_buf} // [RL25]
		: 32'h00000000;
	wire [SMSC_CTRL_W-1:0] ctrl_write = {
		s_axi_wstrb[1] ? s_axi_wdata[SMSC_CTRL_W-1:SMSC_CTRL_LOW_W] : ctrl[SMSC_CTRL_W-1:SMSC_CTRL_LOW_W],
		s_axi_wstrb[0] ? s_axi_wdata[SMSC_CTRL_LOW_W-1:0] : ctrl[SMSC_CTRL_LOW_W-1:0]};

	// controller engine: idle until a byte is loaded
	always_comb
	begin
		next_state = state;
		unique case (state)
			SMSC_IDLE:
				if (start)
					next_state = SMSC_SHIFT; // [RL1]
			SMSC_SHIFT:
				// demotion or disable abandons the byte
				if (done_c | ~is_ctrl)
					next_state = SMSC_IDLE; // [RL2] [RL22]
		endcase
	end

	// state register
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			state <= SMSC_IDLE;
		else
			state <= next_state;
	end

	// clock divider and edge counter, held at SMSC_DIV_START and zero while idle
	always_ff @(posedge ref_clk)
	begin
		if (reset || state == SMSC_IDLE)
		begin
			div_cnt <= SMSC_DIV_START;
			edge_cnt <= 5'h00;
			sck_phase <= 1'b0; // [RL23]
		end
		else if (tick)
		begin
			div_cnt <= SMSC_DIV_START; // [RL24]
			edge_cnt <= edge_cnt + 5'h01;
			sck_phase <= ~sck_phase;
		end
		else
			div_cnt <= div_cnt + 7'h01;
	end

	// bit counter for both roles
	always_ff @(posedge ref_clk)
	begin
		if (reset || bit_clr)
			bit_cnt <= 3'h0;
		else if (sample)
			bit_cnt <= bit_cnt + 3'h1; // wraps to zero on the eighth bit
	end

	// shift register: load, exchange, or restore on deselect
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			sh <= 8'h00;
		else if (load)
			sh <= s_axi_wdata[7:0]; // [RL25]
		else if (sample)
			sh <= shifted; // [RL6]
		else if (tgt_drop)
			sh <= tx_byte; // [RL21]
	end

	// outgoing bit changes only on load, a setup edge, or while a target is deselected
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			out_bit <= 1'b0;
		else if (load)
			out_bit <= wd_first; // [RL17]
		else if (setup || (is_tgt && ss_n_s))
			out_bit <= sh_first; // [RL23]
	end

	// byte kept for a target restore; clock history
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			tx_byte <= 8'h00;
			sck_prev <= 1'b0;
		end
		else
		begin
			if (load)
				tx_byte <= s_axi_wdata[7:0];
			sck_prev <= sck_s;
		end
	end

	// receive buffer; an unread byte is simply overwritten
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			rx_buf <= 8'h00;
		else if (xfer_done)
			rx_buf <= rx_next; // [RL12] [RL14]
	end

	// controller strobes delayed to meet the synchronised data pin
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			samp_dly <= 2'h0;
			done_dly <= 2'h0;
		end
		else
		begin
			samp_dly <= {samp_dly[0], sample_c};
			done_dly <= {done_dly[0], done_c};
		end
	end

	// incoming bits for both roles
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			rx_sh <= 8'h00;
		else if (rx_take)
			rx_sh <= rx_shifted; // [RL6]
	end

	// sticky flags: a new event beats a clear in the same cycle
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			transfer_done_flag <= 1'b0;
			write_collision_flag <= 1'b0;
			armed <= 1'b0;
		end
		else
		begin
			transfer_done_flag <= xfer_done | mode_fault | (transfer_done_flag & ~(data_access & armed)); // [RL2] [RL10]
			write_collision_flag <= collide | (write_collision_flag & ~(data_access & armed)); // [RL19]
			if (read_fire && rd_stat)
				armed <= transfer_done_flag | write_collision_flag;
			else if (data_access)
				armed <= 1'b0;
		end
	end

	// one cycle wake pulse per transfer event
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			wake_request <= 1'b0;
		else
			wake_request <= xfer_done | mode_fault; // [RL20]
	end

	// control and double rate bits; demotion beats a write
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			ctrl <= SMSC_CTRL_RESET;
			double_rate <= 1'b0;
		end
		else
		begin
			if (mode_fault)
				ctrl.controller_select <= 1'b0; // [RL22]
			else if (wr_ctrl)
				ctrl <= ctrl_write;
			if (wr_stat && s_axi_wstrb[0])
				double_rate <= s_axi_wdata[SMSC_STAT_DOUBLE_BIT]; // [RL18]
		end
	end

	// AXI4-Lite write response
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= SMSC_RESP_OKAY;
		end
		else if (write_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_mapped ? SMSC_RESP_OKAY : SMSC_RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// AXI4-Lite read data
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= SMSC_RESP_OKAY;
		end
		else if (read_fire)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= read_word;
			s_axi_rresp <= rd_mapped ? SMSC_RESP_OKAY : SMSC_RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	AST_START_SHIFT: assert property (start |=> state == SMSC_SHIFT && div_cnt == SMSC_DIV_START) // [RL1]
		else $error("loaded byte did not start the clock");
	AST_EIGHT_BITS: assert property (done_c |-> bit_cnt == (ctrl.cpha ? SMSC_LAST_BIT : 3'h0)) // [RL1]
		else $error("controller byte did not hold eight samples");
	AST_STOP_FLAG: assert property (done_c |=> (state == SMSC_IDLE && !sck_phase) ##2 transfer_done_flag) // [RL2]
		else $error("clock did not stop with the done flag");
	AST_IRQ_RAISE: assert property (xfer_done && ctrl.irq_enable && !wr_ctrl |=> irq_request) // [RL3]
		else $error("interrupt missing after transfer");
	AST_TGT_QUIET: assert property (is_tgt && ss_n_s |-> !miso_oe && !sample) // [RL8]
		else $error("target active while deselected");
	AST_TGT_DROP: assert property (is_tgt && ss_n_s && !wr_ctrl |=> bit_cnt == 3'h0) // [RL21]
		else $error("partial byte survived deselect");
	AST_COLLIDE: assert property (collide |=> write_collision_flag && sh == $past(sh_keep)) // [RL19]
		else $error("collision not flagged or data taken");
	AST_RX_KEEP: assert property (xfer_done |=> rx_buf == $past(rx_next)) // [RL12]
		else $error("receive buffer not loaded");
	AST_DEMOTE: assert property (mode_fault |=> !ctrl.controller_select && transfer_done_flag) // [RL22]
		else $error("select fault did not demote");
	AST_DOUBLE_FAST: assert property (double_rate && rate == 2'h0 && tick && !last_edge && !mode_fault && !wr_ctrl
		|=> tick) // [RL18]
		else $error("double speed not every cycle");

	COV_CTRL_BYTE: cover property (done_c);
	COV_TGT_BYTE: cover property (done_t);
	COV_FAULT: cover property (mode_fault);
	COV_COLLIDE: cover property (collide);
endmodule

/* File: rtl/smsc_pkg.sv */
/*
  constants, field layout and types shared by the serial peripheral core.
  assumes a single 250 MHz clock and registers reached over AXI4-Lite.
*/
// Notes on behaviour
// RL1 - controller data write starts eight-bit shift
// RL2 - clock stops after byte, done flag set
// RL3 - done flag plus enable raises interrupt
// RL4 - software selects the target before writing
// RL5 - select low frames a packet, high resyncs
// RL6 - out on MOSI, in on MISO, simultaneously
// RL7 - next write continues, select high ends
// RL8 - target idle while select high, MISO off
// RL9 - target accepts data writes while deselected
// RL10 - target sets done after eight bits in
// RL11 - target may load next before reading
// RL12 - last received byte kept in buffer
// RL13 - no data write before shift completes
// RL14 - read each byte before next completes
// RL15 - remote clock at most quarter rate
// RL16 - pin directions follow role when enabled
// RL17 - selectable LSB-first or MSB-first order
// RL18 - seven rates including half-clock double speed
// RL19 - write during transfer sets collision flag
// RL20 - transfer event wakes processor from idle
// RL21 - target select high drops partial byte
// RL22 - select input low demotes controller, flags
// RL23 - polarity sets idle level, phase sample edge
// RL24 - rate bits divide 4/16/64/128, doubled halves
// RL25 - data read gives buffer, write loads shifter
package smsc_pkg;
	// register byte offsets on the bus
	localparam int SMSC_ADDR_W = 4;
	localparam logic [3:0] SMSC_OFS_CTRL = 4'h0;
	localparam logic [3:0] SMSC_OFS_STATUS = 4'h4;
	localparam logic [3:0] SMSC_OFS_DATA = 4'h8;
	// control register layout, bit 10 down to bit 0
	typedef struct packed {
		logic miso_user_en;
		logic ss_level;
		logic ss_is_output;
		logic irq_enable;
		logic enable;
		logic bit_order_select;
		logic controller_select;
		logic cpol;
		logic cpha;
		logic rate_select_hi;
		logic rate_select_lo;
	} smsc_ctrl_type;
	localparam int SMSC_CTRL_W = 11;
	localparam int SMSC_CTRL_LOW_W = 8;
	// select output level high (deselected) out of reset; the pin is not driven
	localparam smsc_ctrl_type SMSC_CTRL_RESET = 11'h200;
	// status register bit positions
	localparam int SMSC_STAT_FLAG_BIT = 7;
	localparam int SMSC_STAT_WRITE_COLLISION_FLAG_BIT = 6;
	localparam int SMSC_STAT_DOUBLE_BIT = 0;
	// clock half periods in cycles, indexed by the two rate bits
	localparam logic [3:0][6:0] SMSC_HALF_NORMAL = {7'h40, 7'h20, 7'h08, 7'h02};
	localparam logic [3:0][6:0] SMSC_HALF_DOUBLE = {7'h20, 7'h10, 7'h04, 7'h01};
	localparam logic [6:0] SMSC_DIV_START = 7'h01;
	// sixteen clock edges per byte, eight sampled bits
	localparam logic [4:0] SMSC_LAST_EDGE = 5'h0F;
	localparam logic [2:0] SMSC_LAST_BIT = 3'h7;
	// AXI4-Lite responses
	localparam logic [1:0] SMSC_RESP_OKAY = 2'h0;
	localparam logic [1:0] SMSC_RESP_SLVERR = 2'h2;
	// controller shift engine
	typedef enum logic {SMSC_IDLE, SMSC_SHIFT} smsc_state_type;
endpackage

/* File: rtl/smsc_sync.sv */
/*
  two flip-flop synchroniser, one stage pair per bit.
  assumes inputs are asynchronous pins; reset level given per bit.
*/
`timescale 1ns/1ns
module smsc_sync
	import smsc_pkg::*;
#(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	// first stage is seen only by the second stage
	logic [WIDTH-1:0] meta;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			// one synchroniser pair per pin
			always_ff @(posedge ref_clk)
			begin
				if (reset)
				begin
					meta[i] <= RESET_VALUE[i];
					sync_out[i] <= RESET_VALUE[i];
				end
				else
				begin
					meta[i] <= async_in[i];
					sync_out[i] <= meta[i];
				end
			end
		end
	endgenerate
endmodule

/* File: bench/smsc_remote.sv */
/*
  remote serial party: target for a controller core, or controller by task.
  assumes clock mode zero and that the bench resolves the shared lines.
*/
`timescale 1ns/1ns
module smsc_remote
	import smsc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sck,
	input wire logic ss_n,
	input wire logic din,
	output logic dout,
	output logic sck_drv,
	output logic ss_drv
);
	logic [7:0] tx; // next byte to send
	logic [7:0] rx; // bits received so far
	logic [7:0] sh; // outgoing shifter
	logic last; // last bit shown, inverted once released
	initial
	begin
		tx = 8'h00;
		rx = 8'h00;
		sh = 8'h00;
		last = 1'b0;
		sck_drv = 1'b0;
		ss_drv = 1'b1;
	end
	// selection loads the shifter, first bit shows at once
	always @(negedge ss_n)
		sh = tx;
	// sample on the rising edge, only while selected
	always @(posedge sck)
		if (!ss_n)
		begin
			rx = {rx[6:0], din};
			last = sh[7];
		end
	// setup on the falling edge
	always @(negedge sck)
		if (!ss_n)
			sh = {sh[6:0], 1'b0};
	// a released line never shows its stale value
	assign dout = ss_n ? ~last : sh[7];
	// controller role; six-clock half period stays below quarter rate
	task xfer(input logic [7:0] b, input int nb, input logic sel);
		tx = b;
		@(posedge ref_clk);
		ss_drv <= !sel;
		repeat (6) @(posedge ref_clk);
		repeat (nb)
		begin
			sck_drv <= 1'b1;
			repeat (6) @(posedge ref_clk);
			sck_drv <= 1'b0;
			repeat (6) @(posedge ref_clk);
		end
		ss_drv <= 1'b1; // deselect resynchronises the target
		repeat (8) @(posedge ref_clk);
	endtask
endmodule

/* File: bench/tb_spi_master_slave_core.sv */
/*
  self-checking bench for the serial core: bus tasks, both link roles.
  assumes the remote model in smsc_remote and registers at package offsets.
*/
`timescale 1ns/1ns
module tb_spi_master_slave_core
	import smsc_pkg::*;
;
	logic ref_clk, reset, lead;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, ss_n_out, ss_n_oe;
	logic irq_request, wake_request, rem_dout, rem_sck, rem_ss;
	wire logic sck, mosi, miso, ss_n;
	int err_count, checked, wakes;
	// resolve shared lines; the remote holds select high when idle
	assign sck = sck_oe ? sck_out : rem_sck;
	assign mosi = mosi_oe ? mosi_out : rem_dout;
	assign miso = miso_oe ? miso_out : rem_dout;
	assign ss_n = ss_n_oe ? ss_n_out : rem_ss;
	smsc_core i_dut (.ref_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .sck_in(sck), .sck_out, .sck_oe, .mosi_in(mosi), .mosi_out,
		.mosi_oe, .miso_in(miso), .miso_out, .miso_oe, .ss_n_in(ss_n), .ss_n_out, .ss_n_oe,
		.irq_request, .wake_request);
	smsc_remote i_remote (.ref_clk, .sck, .ss_n, .din(lead ? miso : mosi), .dout(rem_dout),
		.sck_drv(rem_sck), .ss_drv(rem_ss));
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// count wake pulses for the transfer checks
	always @(posedge ref_clk)
		if (wake_request === 1'b1)
			wakes++;
	task close_out;
		if (err_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task hang;
		err_count++;
		close_out;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			$display("wrong value at %0t ns: got %h expected %h", $time, g, e);
			err_count++;
		end
	endtask
	// one write; address and data offered together, held until taken
	task wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rs);
		int n;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin @(posedge ref_clk); n++; end while (s_axi_awready !== 1'b1 && n < 50);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		while (s_axi_bvalid !== 1'b1 && n < 100) begin @(posedge ref_clk); n++; end
		if (n >= 100)
			hang;
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	// one read; rready stays up until rvalid is seen
	task rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rs);
		int n;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin @(posedge ref_clk); n++; end while (s_axi_arready !== 1'b1 && n < 50);
		s_axi_arvalid <= 1'b0;
		do begin @(posedge ref_clk); n++; end while (s_axi_rvalid !== 1'b1 && n < 100);
		if (n >= 100)
			hang;
		d = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// poll status until the done flag shows; the read also arms clearing
	task poll(output logic [31:0] s);
		int n;
		n = 0;
		do begin rd(SMSC_OFS_STATUS, s, r); n++; end while (s[7] !== 1'b1 && n < 1000);
		if (n >= 1000)
			hang;
	endtask
	// reset values, unmapped place, no pin override while disabled
	task t_reset;
		logic [31:0] v;
		rd(SMSC_OFS_CTRL, v, r);
		chk(v, 32'h200);
		rd(SMSC_OFS_STATUS, v, r);
		chk(v, 32'h0);
		rd(4'hC, v, r);
		chk(r, SMSC_RESP_SLVERR);
		wr(4'hC, 32'hFF, r);
		chk(r, SMSC_RESP_SLVERR);
		chk({sck_oe, mosi_oe, miso_oe, ss_n_oe}, 32'h0);
	endtask
	// controller byte: rate, double speed, order and interrupt set by i; a collision every time
	task t_ctrl(input logic [2:0] i);
		logic [31:0] v, c;
		logic [7:0] b, e8;
		int n, w0;
		i_remote.tx = 8'h3C + {5'h00, i};
		b = 8'hA5 ^ {5'h00, i};
		c = 32'h150 | {24'h0, i[1], 1'b0, i[0], 3'h0, i[1:0]};
		wr(SMSC_OFS_STATUS, {31'h0, i[2]}, r);
		wr(SMSC_OFS_CTRL, c, r);
		w0 = wakes;
		wr(SMSC_OFS_DATA, {24'h0, b}, r);
		n = 0;
		while (sck_out !== 1'b1 && n < 300) begin @(posedge ref_clk); n++; end
		n = 0;
		while (sck_out === 1'b1 && n < 300) begin @(posedge ref_clk); n++; end
		chk(n, i[2] ? SMSC_HALF_DOUBLE[i[1:0]] : SMSC_HALF_NORMAL[i[1:0]]);
		chk({sck_oe, mosi_oe, miso_oe}, 32'h6);
		wr(SMSC_OFS_DATA, 32'hFF, r);
		poll(v);
		chk(v, 32'hC0 | {31'h0, i[2]});
		chk(irq_request, i[1]);
		chk(sck_out, 1'b0);
		chk(wakes - w0, 1);
		rd(SMSC_OFS_DATA, v, r);
		// the remote sends its byte msb first, so lsb-first reception reverses it
		e8 = 8'h3C + {5'h00, i};
		if (i[0])
			e8 = {<<{e8}};
		chk(v, {24'h0, e8});
		e8 = {<<{b}};
		if (!i[0])
			e8 = b;
		chk(i_remote.rx, e8);
		@(posedge ref_clk);
		chk(irq_request, 1'b0);
		wr(SMSC_OFS_CTRL, c | 32'h200, r);
	endtask
	// target role: idle while deselected, partial byte dropped
	task t_target;
		logic [31:0] v;
		lead = 1'b1;
		// drop the double rate bit left by the controller sweep
		wr(SMSC_OFS_STATUS, 32'h0, r);
		wr(SMSC_OFS_CTRL, 32'h440, r);
		wr(SMSC_OFS_DATA, 32'h96, r);
		i_remote.xfer(8'h11, 8, 1'b0);
		chk(miso_oe, 1'b0);
		rd(SMSC_OFS_STATUS, v, r);
		chk(v, 32'h0);
		i_remote.xfer(8'h33, 3, 1'b1);
		i_remote.xfer(8'h5A, 8, 1'b1);
		poll(v);
		chk(v, 32'h80);
		wr(SMSC_OFS_DATA, 32'h69, r);
		rd(SMSC_OFS_DATA, v, r);
		chk(v, 32'h5A);
		chk(i_remote.rx, 8'h96);
		chk({sck_oe, mosi_oe}, 32'h0);
	endtask
	// select input pulled low demotes the controller
	task t_fault;
		logic [31:0] v;
		wr(SMSC_OFS_CTRL, 32'h258, r);
		chk(sck_oe, 1'b1);
		chk(sck_out, 1'b1);
		@(posedge ref_clk);
		i_remote.ss_drv <= 1'b0;
		repeat (8) @(posedge ref_clk);
		rd(SMSC_OFS_CTRL, v, r);
		chk(v, 32'h248);
		rd(SMSC_OFS_STATUS, v, r);
		chk(v, 32'h80);
		chk(sck_oe, 1'b0);
		i_remote.ss_drv <= 1'b1;
	endtask
	initial
	begin
		err_count = 0;
		checked = 0;
		wakes = 0;
		lead = 1'b0;
		reset = 1'b1;
		s_axi_awaddr = 4'h0;
		s_axi_araddr = 4'h0;
		s_axi_wstrb = 4'hF;
		s_axi_wdata = 32'h0;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		t_reset;
		for (int k = 0; k < 8; k++)
			t_ctrl(k[2:0]);
		t_target;
		t_fault;
		close_out;
	end
endmodule
